// ---- vrt_crt_model.sv ----
// behavioural crt monitor that locks to composite sync
`timescale 1ns/1ps
module vrt_crt_model (
  input  wire logic clock,
  input  wire logic csync_n,
  output int        hperiod,
  output int        hlow
);
  // ---------------------------------------------------------------
  // sync separator
  // ---------------------------------------------------------------
  // the tube only sees the sync line, so it times falls and widths
  int   cnt;
  int   low;
  logic prev;

  initial begin
    cnt = 0;
    low = 0;
    prev = 1'b1;
    hperiod = 0;
    hlow = 0;
  end

  always @(posedge clock) begin
    cnt <= cnt + 1;
    if (csync_n === 1'b0) begin
      low <= low + 1;
    end
    if (prev === 1'b1 && csync_n === 1'b0) begin
      hperiod <= cnt;
      cnt <= 1;
      low <= 1;
    end
    if (prev === 1'b0 && csync_n === 1'b1) begin
      hlow <= low;
    end
    prev <= csync_n;
  end
endmodule : vrt_crt_model

// ---- vrt_oneshot.sv ----
// retriggerable digital one-shot used to stretch a trigger into a pulse
`timescale 1ns/1ps
module vrt_oneshot #(
  parameter int W = 12
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         fire,
  input  wire logic [W-1:0] len,
  output logic              active
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         act;
  } vrt_shot_type;

  vrt_shot_type s_q;
  vrt_shot_type s_d;

  always_comb begin
    s_d = s_q;
    if (fire) begin
      s_d.cnt = len;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - W'(1);
    end
    s_d.act = (s_d.cnt != '0);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign active = s_q.act;

endmodule : vrt_oneshot

// ---- vrt_pkg.sv ----
// constants shared by the raster timing generator files
package vrt_pkg;

  // ---------------------------------------------------------------
  // clock and horizontal timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SLOT_NS     = 4500;  // carry / sync slot, 4.5 us
  localparam int T_SWEEP_NS    = 58500; // one sweep, 58.5 us
  localparam int STAGE1_DIV    = 9;
  localparam int STAGE2_DIV    = 13;
  localparam int SLOT_CYC      = T_SLOT_NS / CLK_PERIOD_NS;
  localparam int STAGE0_DIV    = SLOT_CYC / STAGE1_DIV;
  localparam int SWEEP_CYC     = T_SWEEP_NS / CLK_PERIOD_NS;

  localparam logic [5:0] PRE_LAST = 6'(STAGE0_DIV - 1);
  localparam logic [3:0] S1_LAST  = 4'(STAGE1_DIV - 1);
  localparam logic [3:0] S2_TOP   = 4'hf;
  localparam logic [3:0] S2_LOAD  = 4'(16 - STAGE2_DIV);

  // ---------------------------------------------------------------
  // vertical timing
  // ---------------------------------------------------------------
  localparam int SWEEPS_PER_LINE = 15;
  localparam int LINES           = 16;
  localparam int VISIBLE_SWEEPS  = 240;
  localparam int FRAME_SWEEPS    = 277;
  localparam int BLANK_SWEEPS    = FRAME_SWEEPS - VISIBLE_SWEEPS;
  // nominal figures, rounded, kept for reference; no check uses them
  localparam int T_LINE_US       = 877;
  localparam int T_VISIBLE_US    = 14040;
  localparam int T_FRAME_US      = 16205;

  localparam logic [3:0] SWEEP_RST  = 4'(SWEEPS_PER_LINE);
  localparam logic [3:0] LINE_LAST  = 4'(LINES - 1);
  localparam logic [5:0] BLANK_LAST = 6'(BLANK_SWEEPS - 1);
  localparam logic [3:0] VS_FIRST   = 4'h8;
  localparam logic [3:0] VS_LAST    = 4'(SWEEPS_PER_LINE - 1);

  // ---------------------------------------------------------------
  // horizontal blanking stretch, 10 us to 20 us
  // ---------------------------------------------------------------
  localparam int T_HBLANK_MIN_NS = 10000;
  localparam int T_HBLANK_MAX_NS = 20000;
  localparam int HB_W            = 12;
  localparam logic [HB_W-1:0] HBLANK_MIN_CYC =
    HB_W'((T_HBLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [HB_W-1:0] HBLANK_MAX_CYC =
    HB_W'(T_HBLANK_MAX_NS / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // refresh addressing
  // ---------------------------------------------------------------
  localparam int SYM_W  = 7;
  localparam int ADDR_W = 10;
  localparam int BANKS  = 4;
  localparam logic [SYM_W-1:0] SYM_NARROW_MASK = 7'h3f;

endpackage : vrt_pkg

// ---- vrt_raster.sv ----
// raster timing generator: dividers, counters, blanking, sync, refresh
//
// Overview of operation
// - each sweep lasts 58.5 us, divided from the system clock
// - carry pulse 4.5 us per sweep; hsync same width, 4.5 us later
// - second divider stage divides by 13, reloading its preset on carry
// - sweep counter advances once per sweep on the divider carry
// - sweep counter reset every 15th sweep, low 4.5 us, after carry slot
// - line counter counts groups of 15 sweeps; lsb toggles every line
// - line count msb high in bottom half of displayed area
// - vertical blanking covers retrace sweeps below and above the picture
// - visible raster is 16 lines, 240 sweeps
// - vertical sync recurs every 277 sweeps
// - character lines start 15 sweeps apart
// - symbol counter counts end-of-character strobes; top bit for 64 mode
// - horizontal blanking holds the symbol counter at zero
// - carry triggers horizontal blanking stretched to 10..20 us
// - line and symbol counts multiplexed and decoded to memory address
// - dot blanking gives one pulse per sweep, sampled at character rate
// - composite sync joins inverted horizontal sync with vertical sync
// - horizontal divider divides by fifty, then by nine, then by thirteen
// - line counter carry after 16 lines sets vertical blanking
// - vertical sync after eight blanked sweeps
// - horizontal interruptions continue during vertical sync
`timescale 1ns/1ps
module vrt_raster
  import vrt_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              eoc,
  input  wire logic              wide_mode,
  input  wire logic [HB_W-1:0]   hblank_cycles,
  input  wire logic              cpu_sel,
  input  wire logic [ADDR_W-1:0] cpu_addr,
  output logic                   carry,
  output logic                   hsync,
  output logic                   sweep_rst_n,
  output logic [3:0]             sweep,
  output logic [3:0]             line,
  output logic                   hblank,
  output logic                   vblank,
  output logic                   vsync,
  output logic                   csync_n,
  output logic                   dot_blank,
  output logic [SYM_W-1:0]       symbol,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [BANKS-1:0]       mem_bank
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [5:0]        pre;
    logic [3:0]        s1;
    logic [3:0]        s2;
    logic [3:0]        sweep;
    logic [3:0]        line;
    logic [5:0]        bsweep;
    logic              vblank;
    logic              vsync;
    logic              hsync;
    logic              carry;
    logic              srst_n;
    logic              csync_n;
    logic              dot_blank;
    logic [SYM_W-1:0]  sym;
    logic [ADDR_W-1:0] addr;
    logic [BANKS-1:0]  bank;
  } vrt_state_type;

  vrt_state_type s_q;
  vrt_state_type s_d;

  logic            slot_end;
  logic            carry_end;
  logic            hs_end;
  logic            carry_start;
  logic            hb_active;
  logic [HB_W-1:0] hb_len;

  // ---------------------------------------------------------------
  // horizontal blanking stretch
  // ---------------------------------------------------------------
  // out-of-range settings are clamped so the blank stays in 10..20 us
  always_comb begin
    if (hblank_cycles < HBLANK_MIN_CYC) begin
      hb_len = HBLANK_MIN_CYC;
    end else if (hblank_cycles > HBLANK_MAX_CYC) begin
      hb_len = HBLANK_MAX_CYC;
    end else begin
      hb_len = hblank_cycles;
    end
  end

  vrt_oneshot #(
    .W (HB_W)
  ) u_hblank (
    .clock  (clock),
    .rst    (rst),
    .fire   (carry_start),
    .len    (hb_len),
    .active (hb_active)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  assign slot_end    = (s_q.pre == PRE_LAST) && (s_q.s1 == S1_LAST);
  assign carry_end   = slot_end && (s_q.s2 == S2_TOP);
  assign hs_end      = slot_end && (s_q.s2 == S2_LOAD);
  assign carry_start = slot_end && (s_q.s2 == S2_TOP - 4'h1);

  always_comb begin
    s_d = s_q;
    // divide by 50 then by nine gives one 4.5 us slot
    if (s_q.pre == PRE_LAST) begin
      s_d.pre = '0;
      s_d.s1  = (s_q.s1 == S1_LAST) ? 4'h0 : s_q.s1 + 4'h1;
    end else begin
      s_d.pre = s_q.pre + 6'h01;
    end
    // 13 slots per sweep; preset reload on carry exit
    if (slot_end) begin
      s_d.s2 = (s_q.s2 == S2_TOP) ? S2_LOAD : s_q.s2 + 4'h1;
    end
    // sweep counter steps on carry; reaches 15 only briefly
    if (carry_end) begin
      s_d.sweep = s_q.sweep + 4'h1;
    end
    // self-reset one slot after the 15th carry, advancing the line
    if (hs_end && (s_q.sweep == SWEEP_RST)) begin
      s_d.sweep = '0;
      s_d.line  = s_q.line + 4'h1;
      if (s_q.line == LINE_LAST) begin
        s_d.vblank = 1'b1;
        s_d.bsweep = '0;
      end
    end
    // retrace sweeps are counted; the frame restarts after them
    if (carry_end && s_q.vblank) begin
      if (s_q.bsweep == BLANK_LAST) begin
        s_d.vblank = 1'b0;
        s_d.bsweep = '0;
        s_d.sweep  = '0;
        s_d.line   = '0;
      end else begin
        s_d.bsweep = s_q.bsweep + 6'h01;
      end
    end
    // decoder enabled by blanking, first retrace line only
    s_d.vsync = s_d.vblank && (s_d.line == 4'h0) &&
                (s_d.sweep >= VS_FIRST) &&
                (s_d.sweep <= VS_LAST);
    s_d.carry  = (s_d.s2 == S2_TOP);
    s_d.hsync  = (s_d.s2 == S2_LOAD);
    s_d.srst_n = !(s_d.hsync && (s_d.sweep == SWEEP_RST));
    // during vsync the carry notches keep the line oscillator locked
    if (s_d.vsync) begin
      s_d.csync_n = s_d.carry;
    end else begin
      s_d.csync_n = !s_d.hsync;
    end
    // blanking sampled at character rate, so it aligns with dots
    if (eoc) begin
      s_d.dot_blank = hb_active;
    end
    // symbol counter held at zero through horizontal blanking
    if (hb_active) begin
      s_d.sym = '0;
    end else if (eoc) begin
      s_d.sym = s_q.sym + 7'h01;
    end
    if (!wide_mode) begin
      s_d.sym = s_d.sym & SYM_NARROW_MASK;
    end
    // refresh address unless the processor owns the memory
    if (cpu_sel) begin
      s_d.addr = cpu_addr;
    end else if (wide_mode) begin
      s_d.addr = {s_d.line, s_d.sym[5:0]};
    end else begin
      s_d.addr = {1'b0, s_d.line, s_d.sym[4:0]};
    end
    s_d.bank = BANKS'(1) << s_d.addr[ADDR_W-1 -: 2];
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q         <= '0;
      s_q.s2      <= S2_LOAD;
      s_q.hsync   <= 1'b1;
      s_q.srst_n  <= 1'b1;
      s_q.csync_n <= 1'b0;
      s_q.bank    <= BANKS'(1);
    end else begin
      s_q <= s_d;
    end
  end

  assign carry       = s_q.carry;
  assign hsync       = s_q.hsync;
  assign sweep_rst_n = s_q.srst_n;
  assign sweep       = s_q.sweep;
  assign line        = s_q.line;
  assign hblank      = hb_active;
  assign vblank      = s_q.vblank;
  assign vsync       = s_q.vsync;
  assign csync_n     = s_q.csync_n;
  assign dot_blank   = s_q.dot_blank;
  assign symbol      = s_q.sym;
  assign mem_addr    = s_q.addr;
  assign mem_bank    = s_q.bank;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  localparam int SWEEP_GAP = SWEEP_CYC - 1;

  logic [12:0] per_q;
  logic        seen_q;
  logic [9:0]  carry_hi_q;
  logic [9:0]  hsync_hi_q;
  logic [9:0]  srst_lo_q;
  logic [8:0]  frame_q;
  logic        fseen_q;
  logic [7:0]  vis_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      per_q  <= '0;
      seen_q <= 1'b0;
    end else if ($rose(carry)) begin
      per_q  <= '0;
      seen_q <= 1'b1;
    end else begin
      per_q <= per_q + 13'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      carry_hi_q <= '0;
      hsync_hi_q <= '0;
      srst_lo_q  <= '0;
      frame_q    <= '0;
      fseen_q    <= 1'b0;
      vis_q      <= '0;
    end else begin
      carry_hi_q <= carry ? carry_hi_q + 10'h001 : '0;
      hsync_hi_q <= hsync ? hsync_hi_q + 10'h001 : '0;
      srst_lo_q  <= sweep_rst_n ? '0 : srst_lo_q + 10'h001;
      if ($rose(vsync)) begin
        frame_q <= 9'h001;
        fseen_q <= 1'b1;
      end else if ($fell(carry)) begin
        frame_q <= frame_q + 9'h001;
      end
      if ($fell(vblank)) begin
        vis_q <= '0;
      end else if ($fell(carry) && !vblank) begin
        vis_q <= vis_q + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sweep_period_a: assert property (
    $rose(carry) && seen_q |-> per_q == 13'(SWEEP_GAP))
    else $error("sweep period is not 58.5 us");

  hsync_follows_a: assert property (
    $fell(carry) |-> hsync)
    else $error("hsync does not follow the carry slot");

  hsync_width_a: assert property (
    $fell(hsync) |-> hsync_hi_q == 10'(SLOT_CYC) && !carry)
    else $error("hsync width is not 4.5 us");

  preset_reload_a: assert property (
    $fell(carry) |-> s_q.s2 == S2_LOAD)
    else $error("second divider did not reload its preset");

  sweep_step_a: assert property (
    $changed(sweep) && sweep != 4'h0 |-> $fell(carry))
    else $error("sweep counter moved without a carry");

  sweep_reset_a: assert property (
    $fell(sweep_rst_n) |-> sweep == SWEEP_RST && hsync)
    else $error("sweep reset pulse misplaced");

  sweep_release_a: assert property (
    $rose(sweep_rst_n) |-> srst_lo_q == 10'(SLOT_CYC) && sweep == 4'h0)
    else $error("sweep reset pulse width or release wrong");

  line_step_a: assert property (
    $changed(line) && !(line == 4'h0 && $fell(vblank))
      |-> $rose(sweep_rst_n))
    else $error("line counter moved outside a sweep reset");

  vblank_set_a: assert property (
    $rose(vblank) |-> line == 4'h0 && $past(line) == LINE_LAST)
    else $error("vertical blanking set without line carry");

  vsync_window_a: assert property (
    vsync |-> vblank && sweep >= VS_FIRST && line == 4'h0)
    else $error("vertical sync outside its blanked window");

  csync_notch_a: assert property (
    vsync && carry |-> csync_n)
    else $error("carry notch missing during vertical sync");

  symbol_hold_a: assert property (
    hblank |=> symbol == '0)
    else $error("symbol counter not held during blanking");

  narrow_mode_a: assert property (
    !wide_mode |=> !symbol[SYM_W-1])
    else $error("extra symbol bit set in narrow mode");

  carry_width_a: assert property (
    $fell(carry) |-> carry_hi_q == 10'(SLOT_CYC))
    else $error("carry pulse width is not 4.5 us");

  frame_period_a: assert property (
    $rose(vsync) && fseen_q |-> frame_q == 9'(FRAME_SWEEPS))
    else $error("frame is not 277 sweeps");

  visible_sweeps_a: assert property (
    $rose(vblank) |-> vis_q == 8'(VISIBLE_SWEEPS))
    else $error("visible raster is not 240 sweeps");

  hblank_start_a: assert property (
    $rose(carry) |-> $rose(hblank))
    else $error("horizontal blanking not started by carry");

  dot_sample_a: assert property (
    eoc |=> dot_blank == $past(hblank))
    else $error("dot blanking not sampled on end of character");

  csync_mix_a: assert property (
    !vsync |-> csync_n == !hsync)
    else $error("composite sync does not follow hsync");

  vsync_seen_c: cover property ($rose(vsync));
  frame_wrap_c: cover property ($fell(vblank));
  wide_top_c:   cover property (wide_mode && symbol[SYM_W-1]);
  cpu_take_c:   cover property (cpu_sel ##1 !cpu_sel);
  line_step_c:  cover property ($rose(sweep_rst_n));

endmodule : vrt_raster

// ---- vrt_raster_test.sv ----
// self-checking bench for the raster timing generator
`timescale 1ns/1ps
module vrt_raster_test
  import vrt_pkg::*;
;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic              eoc = 1'b0;
  logic              wide_mode = 1'b0;
  logic [HB_W-1:0]   hblank_cycles = 12'h5dc;
  logic              cpu_sel = 1'b0;
  logic [ADDR_W-1:0] cpu_addr = 10'h000;
  logic              carry, hsync, sweep_rst_n, hblank;
  logic              vblank, vsync, csync_n, dot_blank;
  logic [3:0]        sweep, line;
  logic [SYM_W-1:0]  symbol;
  logic [ADDR_W-1:0] mem_addr;
  logic [BANKS-1:0]  mem_bank;
  int                hperiod, hlow, n;
  int                error_cnt = 0;
  int                n_tests = 0;

  always #5 clock = ~clock;

  vrt_raster i_vrt_raster (.clock(clock), .rst(rst), .eoc(eoc),
    .wide_mode(wide_mode), .hblank_cycles(hblank_cycles),
    .cpu_sel(cpu_sel), .cpu_addr(cpu_addr), .carry(carry),
    .hsync(hsync), .sweep_rst_n(sweep_rst_n), .sweep(sweep),
    .line(line), .hblank(hblank), .vblank(vblank), .vsync(vsync),
    .csync_n(csync_n), .dot_blank(dot_blank), .symbol(symbol),
    .mem_addr(mem_addr), .mem_bank(mem_bank));

  vrt_crt_model i_vrt_crt_model (.clock(clock), .csync_n(csync_n),
    .hperiod(hperiod), .hlow(hlow));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // inputs move and outputs are read 1 ns after the edge
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_tests++;
    if (exp !== got) begin
      error_cnt++;
      $display("FAIL %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check

  function automatic logic pick(input int k);
    case (k)
      0: return carry;
      1: return hsync;
      2: return hblank;
      3: return !sweep_rst_n;
      default: return sweep === 4'hf;
    endcase
  endfunction : pick

  task automatic wait_level(input int k, input logic v, input int bound);
    int w = 0;
    while (pick(k) !== v) begin
      tick();
      w++;
      if (w > bound) begin
        error_cnt++;
        $display("FAIL wait%0d expected %0d seen timeout", k, v);
        summarize();
      end
    end
  endtask : wait_level

  task automatic measure(input int k, output int cnt);
    cnt = 0;
    while (pick(k) === 1'b1) begin
      cnt++;
      tick();
      if (cnt > 8000) begin
        error_cnt++;
        $display("FAIL pulse%0d expected end seen timeout", k);
        summarize();
      end
    end
  endtask : measure

  task automatic pulse(input int cnt);
    repeat (cnt) begin
      eoc = 1'b1;
      tick();
      eoc = 1'b0;
      tick();
    end
  endtask : pulse

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic reset_check();
    check("sweep", 0, sweep);
    check("line", 0, line);
    check("vblank", 0, vblank);
    check("vsync", 0, vsync);
    check("carry", 0, carry);
    check("hblank", 0, hblank);
  endtask : reset_check

  task automatic addr_check();
    cpu_sel = 1'b1;
    for (int b = 0; b < 4; b++) begin
      cpu_addr = {b[1:0], 8'h5a};
      tick();
      tick();
      check("mem_addr", {b[1:0], 8'h5a}, mem_addr);
      check("mem_bank", 16'h1 << b, mem_bank);
    end
    cpu_sel = 1'b0;
    tick();
    tick();
    check("refresh", 0, mem_addr);
  endtask : addr_check

  task automatic sweep_check();
    wait_level(0, 1'b1, 6000);
    check("hblank_start", 1, hblank);
    measure(0, n);
    check("carry_w", 450, n);
    check("sweep_inc", 1, sweep);
    measure(1, n);
    check("hsync_w", 450, n);
    n = 0;
    while (carry !== 1'b1 && n < 6000) begin
      tick();
      n++;
    end
    check("rest", 4950, n);
  endtask : sweep_check

  task automatic hblank_check(input logic [HB_W-1:0] len, input int exp);
    hblank_cycles = len;
    wait_level(0, 1'b0, 6000);
    wait_level(0, 1'b1, 6000);
    measure(2, n);
    check("hblank_w", exp, n);
  endtask : hblank_check

  task automatic symbol_check();
    wait_level(2, 1'b0, 3000);
    wide_mode = 1'b1;
    pulse(70);
    tick();
    check("sym_wide", 70, symbol);
    check("addr_wide", 6, mem_addr);
    check("dot_vis", 0, dot_blank);
    wide_mode = 1'b0;
    pulse(10);
    tick();
    check("sym_narrow", 16, symbol);
    check("addr_narrow", 16, mem_addr);
    wait_level(0, 1'b1, 6000);
    tick();
    check("sym_clr", 0, symbol);
    pulse(1);
    check("sym_held", 0, symbol);
    check("dot_blk", 1, dot_blank);
  endtask : symbol_check

  task automatic line_check();
    wait_level(4, 1'b1, 80000);
    wait_level(3, 1'b1, 6000);
    check("rst_slot", 1, hsync);
    measure(3, n);
    check("sweep_rst_w", 450, n);
    check("sweep_wrap", 0, sweep);
    check("line_inc", 1, line);
    check("vblank_vis", 0, vblank);
    check("hperiod", 5850, hperiod);
    check("hlow", 450, hlow);
  endtask : line_check

  task automatic restart_check();
    rst = 1'b1;
    repeat (3) tick();
    rst = 1'b0;
    tick();
    reset_check();
    check("hsync_rst", 1, hsync);
    check("srst_rst", 1, sweep_rst_n);
    check("sym_rst", 0, symbol);
    check("bank_rst", 1, mem_bank);
  endtask : restart_check

  initial begin
    repeat (3) tick();
    rst = 1'b0;
    tick();
    reset_check();
    addr_check();
    sweep_check();
    hblank_check(12'h5dc, 1500);
    hblank_check(12'h1f4, 1000);
    hblank_check(12'hbb8, 2000);
    symbol_check();
    line_check();
    restart_check();
    summarize();
  end
endmodule : vrt_raster_test
